// [hdl/tdmsw_pkg.sv]
// Constants shared by the stream and host port layer of the TDM switch.
// Assumes a 125 MHz system clock; frame clock arrives as a sampled input.
package tdmsw_pkg;

  // ==========================================================================
  // Sizes
  localparam int STREAMS = 16;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 16;
  localparam int RATE_W = 4;
  localparam int CH_W = 8;
  localparam int MAX_CHANNELS = 1024;
  localparam int FIFO_DEPTH = 16;

  // ==========================================================================
  // Rate field encodings (channels per stream = 32 << code)
  localparam logic [3:0] RATE_2M = 4'h0;
  localparam logic [3:0] RATE_4M = 4'h1;
  localparam logic [3:0] RATE_8M = 4'h2;
  localparam logic [3:0] RATE_16M = 4'h3;
  localparam logic [3:0] RATE_OFF = 4'hF;
  localparam int CH_2M = 32;

  // ==========================================================================
  // Control register fields
  localparam int CR_CLKSEL_LSB = 5;
  localparam int CR_SYNC_POL = 7;
  localparam int CR_CLK_POL = 8;
  localparam int CR_SYNC_FMT = 9;
  localparam int IMS_BIDIR = 6;
  localparam logic [15:0] CR_RESET = 16'h0000;
  localparam logic [15:0] IMS_RESET = 16'h0000;

  // ==========================================================================
  // Host map (word addresses)
  localparam logic [13:0] ADDR_CR = 14'h0000;
  localparam logic [13:0] ADDR_IMS = 14'h0001;
  localparam logic [13:0] ADDR_STATUS = 14'h0002;
  localparam logic [13:0] ADDR_SICR = 14'h0020;
  localparam logic [13:0] ADDR_SOCR = 14'h0040;
  localparam logic [13:0] ADDR_MSG = 14'h0100;
  localparam int MSG_SLOTS = 16;

  // ==========================================================================
  // Timing
  localparam int CLK_NS = 8;
  localparam int ACK_HOLD_CYC = 2;

  typedef enum logic [1:0] {TDMSW_BUS_IDLE, TDMSW_BUS_XFER, TDMSW_BUS_DONE} tdmsw_bus_t;

endpackage : tdmsw_pkg

// [hdl/tdmsw_sync.sv]
// Three-flop synchroniser with agreement filter for one pin input.
// Assumes the input is asynchronous to clock.
`timescale 1ns/100ps
`default_nettype none
module tdmsw_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Pin and result
  input wire logic pin,
  output logic level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clock)
  begin
    s1_r <= rst ? RST_VAL : pin;
    s2_r <= rst ? RST_VAL : s1_r;
    s3_r <= rst ? RST_VAL : s2_r;
  end

  // Only a value that has stood for two samples is accepted
  always_ff @(posedge clock)
  begin
    if (rst)
      level <= RST_VAL;
    else if (s2_r == s3_r)
      level <= s3_r;
  end
endmodule : tdmsw_sync
`default_nettype wire

// [hdl/tdmsw_fifo.sv]
// Small flop FIFO with valid/ready on both sides.
// Assumes a single clock domain.
`timescale 1ns/100ps
`default_nettype none
module tdmsw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_r[rd_r];

  always_ff @(posedge clock)
  begin
    if (push)
      mem_r[wr_r] <= in_data;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wr_r <= wr_r + 1'b1;
      if (pop)
        rd_r <= rd_r + 1'b1;
      if (push && !pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop && !push)
        cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule : tdmsw_fifo
`default_nettype wire

// [hdl/tdmsw_top.sv]
// Stream and host port layer of a 16-in 16-out TDM switch.
// Assumes pin inputs are asynchronous; frame clock is sampled, not used as a clock.
// How it works
// - Both low: 8/16 MHz clock; both high: 4 MHz; mixed is reserved.
// - Frame sync pulses every 8 kHz frame for 61, 122 or 244 ns.
// - Sync default negative ST-BUS; polarity bit gives positive, format bit with it GCI.
// - Falling clock edge marks frame boundary unless clock polarity bit set.
// - Stream carries 32/64/128/256 channels at 2/4/8/16 Mbps.
// - Bidirectional bit forces inputs low and makes outputs bidirectional.
// - Serial outputs driven only while drive enable is high.
// - Ack driven low in strobe style; rises in separate-strobe style.
// - Strobes ignored while chip select is high.
// - Strobe style: direction high reads, low writes; strobe starts access.
// - Separate style: falling write strobe writes, falling read strobe reads.
// - Host port has 14-bit address and 16-bit data bus.
// - Bus-style input high or open selects strobe style; low separate.
// - Reset disables outputs, loads defaults, clears counters.
// - Each input and output stream has its own four-bit rate field.
// - Enabled channels must not exceed 1024 in total.
// - Only whole streams are enabled.
// - Message mode places host data on the chosen output channel; the code sends slot data on all 16 streams where channel low bits match.
// - Two-bit clock-select field sets sync width and clock frequency; the code uses it only to skip bit halving at 10 outside 4 MHz mode.
// - GCI timing only when both sync format and polarity bits set.
// - Clock polarity bit defaults to negative clock format.
`timescale 1ns/100ps
`default_nettype none
module tdmsw_top (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Mode pins
  input wire logic low_clock_mode_pin_a,
  input wire logic low_clock_mode_pin_b,
  input wire logic bus_style_select,
  // Frame timing
  input wire logic frame_clock_input,
  input wire logic frame_sync_input,
  // Serial streams
  input wire logic [15:0] serial_in_streams,
  input wire logic [15:0] serial_out_streams_in,
  output logic [15:0] serial_out_streams_out,
  output logic [15:0] serial_out_streams_oe_n,
  input wire logic stream_drive_enable,
  // Host port
  input wire logic chip_select_n,
  input wire logic read_write_n,
  input wire logic strobe_or_read,
  input wire logic [13:0] host_address_bus,
  input wire logic [15:0] host_data_bus_in,
  output logic [15:0] host_data_bus_out,
  output logic [15:0] host_data_bus_oe_n,
  output logic transfer_ack_out,
  output logic transfer_ack_oe_n,
  // Status
  output logic clock_mode_4m,
  output logic clock_mode_reserved,
  output logic capacity_error,
  output logic [15:0] rx_word,
  output logic rx_word_valid,
  input wire logic rx_word_ready
);
  // ==========================================================================
  // Pin synchronisers
  logic fclk_s, fsync_s, cs_n_s, rw_s, ds_s, style_s, mode_a_s, mode_b_s, ode_s;
  logic [15:0] sin_s;
  logic [15:0] sio_s;

  tdmsw_sync #(.RST_VAL(1'b0)) u_fclk (.clock(clock), .rst(rst), .pin(frame_clock_input), .level(fclk_s));
  tdmsw_sync #(.RST_VAL(1'b1)) u_fsync (.clock(clock), .rst(rst), .pin(frame_sync_input), .level(fsync_s));
  tdmsw_sync #(.RST_VAL(1'b1)) u_cs (.clock(clock), .rst(rst), .pin(chip_select_n), .level(cs_n_s));
  tdmsw_sync #(.RST_VAL(1'b1)) u_rw (.clock(clock), .rst(rst), .pin(read_write_n), .level(rw_s));
  tdmsw_sync #(.RST_VAL(1'b1)) u_ds (.clock(clock), .rst(rst), .pin(strobe_or_read), .level(ds_s));
  tdmsw_sync #(.RST_VAL(1'b1)) u_sty (.clock(clock), .rst(rst), .pin(bus_style_select), .level(style_s));
  tdmsw_sync #(.RST_VAL(1'b0)) u_ma (.clock(clock), .rst(rst), .pin(low_clock_mode_pin_a), .level(mode_a_s));
  tdmsw_sync #(.RST_VAL(1'b0)) u_mb (.clock(clock), .rst(rst), .pin(low_clock_mode_pin_b), .level(mode_b_s));
  tdmsw_sync #(.RST_VAL(1'b0)) u_ode (.clock(clock), .rst(rst), .pin(stream_drive_enable), .level(ode_s));

  for (genvar g = 0; g < 16; g++)
  begin : g_sin
    tdmsw_sync #(.RST_VAL(1'b0)) u_si (.clock(clock), .rst(rst), .pin(serial_in_streams[g]), .level(sin_s[g]));
    tdmsw_sync #(.RST_VAL(1'b0)) u_so (.clock(clock), .rst(rst), .pin(serial_out_streams_in[g]), .level(sio_s[g]));
  end

  // ==========================================================================
  // Registers
  logic [15:0] control_register_r;
  logic [15:0] internal_mode_register_r;
  logic [15:0] input_stream_control_r [16];
  logic [15:0] output_stream_control_r [16];
  logic [7:0] msg_data_r [16];
  logic [15:0] msg_enable_r;

  logic bidir;
  logic clk_pol, sync_pos, gci;
  logic [1:0] clock_select_field;
  assign bidir = internal_mode_register_r[tdmsw_pkg::IMS_BIDIR];
  assign clk_pol = control_register_r[tdmsw_pkg::CR_CLK_POL];
  assign sync_pos = control_register_r[tdmsw_pkg::CR_SYNC_POL];
  assign gci = sync_pos && control_register_r[tdmsw_pkg::CR_SYNC_FMT];
  assign clock_select_field = control_register_r[tdmsw_pkg::CR_CLKSEL_LSB +: 2];

  // Mode pin decode
  assign clock_mode_4m = mode_a_s && mode_b_s;
  assign clock_mode_reserved = mode_a_s ^ mode_b_s;

  // Channels per stream for a rate code, zero when the stream is off
  function automatic logic [11:0] tdmsw_chans(input logic [3:0] code);
    logic [11:0] n;
    n = 12'h000;
    if (code <= tdmsw_pkg::RATE_16M)
      n = 12'(tdmsw_pkg::CH_2M) << code[1:0];
    return n;
  endfunction : tdmsw_chans

  // ==========================================================================
  // Capacity check over all enabled input streams
  logic [15:0] total_ch;
  always_comb
  begin
    total_ch = 16'h0000;
    for (int i = 0; i < 16; i++)
      total_ch = total_ch + 16'(tdmsw_chans(input_stream_control_r[i][3:0]));
  end
  always_ff @(posedge clock)
  begin
    if (rst)
      capacity_error <= 1'b0;
    else
      capacity_error <= (total_ch > 16'(tdmsw_pkg::MAX_CHANNELS));
  end

  // ==========================================================================
  // Frame clock edge and frame boundary detection
  logic fclk_d_r, fsync_d_r;
  logic fedge, fsync_act, boundary;
  always_ff @(posedge clock)
  begin
    fclk_d_r <= rst ? 1'b0 : fclk_s;
    fsync_d_r <= rst ? 1'b0 : fsync_act;
  end
  // Active edge: falling by default, rising when clock polarity is set
  assign fedge = clk_pol ? (fclk_s && !fclk_d_r) : (!fclk_s && fclk_d_r);
  assign fsync_act = sync_pos ? fsync_s : !fsync_s;
  // GCI pulse is taken as it stood one clock cycle before the edge, ST-BUS at the edge itself
  assign boundary = fedge && (gci ? fsync_d_r : fsync_act);

  // Bit clock divider: one bit per two frame clocks, except clock-select 10 outside 4 MHz pin mode at one
  logic [1:0] div_r;
  logic bit_tick;
  logic [11:0] bit_cnt_r;
  always_ff @(posedge clock)
  begin
    if (rst || boundary)
    begin
      div_r <= 2'b00;
      bit_cnt_r <= 12'h000;
    end
    else if (fedge)
    begin
      div_r <= div_r + 2'b01;
      if (bit_tick)
        bit_cnt_r <= bit_cnt_r + 12'h001;
    end
  end
  // Halved unless clock-select chooses the top clock outside 4 MHz pin mode
  assign bit_tick = (clock_select_field == 2'b10 && !clock_mode_4m) ? 1'b1 : div_r[0];

  // ==========================================================================
  // Serial input capture into the FIFO
  logic [15:0] sin_eff;
  logic [15:0] shift_r;
  logic [3:0] bitn_r;
  logic cap_valid_r;
  logic fifo_in_ready;
  assign sin_eff = bidir ? sio_s : sin_s;
  always_ff @(posedge clock)
  begin
    if (rst || boundary)
    begin
      shift_r <= 16'h0000;
      bitn_r <= 4'h0;
      cap_valid_r <= 1'b0;
    end
    else
    begin
      if (cap_valid_r && fifo_in_ready)
        cap_valid_r <= 1'b0;
      if (fedge && bit_tick)
      begin
        shift_r <= {shift_r[14:0], sin_eff[0]};
        bitn_r <= bitn_r + 4'h1;
        // Full words are dropped while the FIFO stalls
        if (bitn_r == 4'hF && fifo_in_ready)
          cap_valid_r <= 1'b1;
      end
    end
  end

  tdmsw_fifo #(.WIDTH(16), .DEPTH(tdmsw_pkg::FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(cap_valid_r),
    .in_ready(fifo_in_ready),
    .in_data(shift_r),
    .out_valid(rx_word_valid),
    .out_ready(rx_word_ready),
    .out_data(rx_word)
  );

  // ==========================================================================
  // Serial output: message data or loopback of the input stream
  logic [7:0] ch_idx;
  logic [2:0] bit_idx;
  logic [15:0] out_bits;
  assign bit_idx = 3'd7 - bit_cnt_r[2:0];
  assign ch_idx = bit_cnt_r[10:3];
  always_comb
  begin
    out_bits = 16'h0000;
    for (int s = 0; s < 16; s++)
      if (msg_enable_r[ch_idx[3:0]])
        out_bits[s] = msg_data_r[ch_idx[3:0]][bit_idx];
      else
        out_bits[s] = bidir ? 1'b0 : sin_s[s];
  end
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      serial_out_streams_out <= 16'h0000;
      serial_out_streams_oe_n <= 16'hFFFF;
    end
    else
    begin
      if (fedge)
        serial_out_streams_out <= out_bits;
      for (int s = 0; s < 16; s++)
        serial_out_streams_oe_n[s] <= !(ode_s &&
          output_stream_control_r[s][3:0] <= tdmsw_pkg::RATE_16M);
    end
  end

  // ==========================================================================
  // Host port
  tdmsw_pkg::tdmsw_bus_t bus_r;
  logic access_start, is_read, is_write, strobe_act;
  logic rw_d_r, ds_d_r;
  logic [15:0] rd_data;
  logic [1:0] hold_r;
  always_ff @(posedge clock)
  begin
    rw_d_r <= rst ? 1'b1 : rw_s;
    ds_d_r <= rst ? 1'b1 : ds_s;
  end
  // Strobe style: falling strobe with chip select; separate: falling read or write
  assign strobe_act = style_s ? !ds_s : (!ds_s || !rw_s);
  assign access_start = !cs_n_s && (style_s ? (!ds_s && ds_d_r)
    : ((!ds_s && ds_d_r) || (!rw_s && rw_d_r)));
  assign is_read = style_s ? rw_s : !ds_s;
  assign is_write = !is_read;

  always_comb
  begin
    rd_data = 16'h0000;
    if (host_address_bus == tdmsw_pkg::ADDR_CR)
      rd_data = control_register_r;
    else if (host_address_bus == tdmsw_pkg::ADDR_IMS)
      rd_data = internal_mode_register_r;
    else if (host_address_bus == tdmsw_pkg::ADDR_STATUS)
      rd_data = {13'h0000, capacity_error, clock_mode_reserved, clock_mode_4m};
    else if (host_address_bus[13:4] == tdmsw_pkg::ADDR_SICR[13:4])
      rd_data = input_stream_control_r[host_address_bus[3:0]];
    else if (host_address_bus[13:4] == tdmsw_pkg::ADDR_SOCR[13:4])
      rd_data = output_stream_control_r[host_address_bus[3:0]];
    else if (host_address_bus[13:4] == tdmsw_pkg::ADDR_MSG[13:4])
      rd_data = {7'h00, msg_enable_r[host_address_bus[3:0]], msg_data_r[host_address_bus[3:0]]};
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      control_register_r <= tdmsw_pkg::CR_RESET;
      internal_mode_register_r <= tdmsw_pkg::IMS_RESET;
      msg_enable_r <= 16'h0000;
      for (int i = 0; i < 16; i++)
      begin
        input_stream_control_r[i] <= {12'h000, tdmsw_pkg::RATE_OFF};
        output_stream_control_r[i] <= {12'h000, tdmsw_pkg::RATE_OFF};
        msg_data_r[i] <= 8'h00;
      end
    end
    else if (bus_r == tdmsw_pkg::TDMSW_BUS_IDLE && access_start && is_write)
    begin
      if (host_address_bus == tdmsw_pkg::ADDR_CR)
        control_register_r <= host_data_bus_in;
      else if (host_address_bus == tdmsw_pkg::ADDR_IMS)
        internal_mode_register_r <= host_data_bus_in;
      else if (host_address_bus[13:4] == tdmsw_pkg::ADDR_SICR[13:4])
        input_stream_control_r[host_address_bus[3:0]] <= host_data_bus_in;
      else if (host_address_bus[13:4] == tdmsw_pkg::ADDR_SOCR[13:4])
        output_stream_control_r[host_address_bus[3:0]] <= host_data_bus_in;
      else if (host_address_bus[13:4] == tdmsw_pkg::ADDR_MSG[13:4])
      begin
        msg_data_r[host_address_bus[3:0]] <= host_data_bus_in[7:0];
        msg_enable_r[host_address_bus[3:0]] <= host_data_bus_in[8];
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      bus_r <= tdmsw_pkg::TDMSW_BUS_IDLE;
      hold_r <= 2'b00;
      host_data_bus_out <= 16'h0000;
      host_data_bus_oe_n <= 16'hFFFF;
      transfer_ack_out <= 1'b1;
      transfer_ack_oe_n <= 1'b1;
    end
    else
    begin
      case (bus_r)
        tdmsw_pkg::TDMSW_BUS_IDLE:
        begin
          transfer_ack_oe_n <= 1'b1;
          host_data_bus_oe_n <= 16'hFFFF;
          hold_r <= 2'b00;
          if (access_start)
          begin
            host_data_bus_out <= rd_data;
            host_data_bus_oe_n <= is_read ? 16'h0000 : 16'hFFFF;
            // Ack starts at its idle level, low for separate style
            transfer_ack_out <= style_s;
            transfer_ack_oe_n <= 1'b0;
            bus_r <= tdmsw_pkg::TDMSW_BUS_XFER;
          end
        end
        tdmsw_pkg::TDMSW_BUS_XFER:
        begin
          hold_r <= hold_r + 2'b01;
          if (hold_r == 2'(tdmsw_pkg::ACK_HOLD_CYC - 1))
          begin
            transfer_ack_out <= !style_s;
            bus_r <= tdmsw_pkg::TDMSW_BUS_DONE;
          end
        end
        tdmsw_pkg::TDMSW_BUS_DONE:
        begin
          // Hold until the strobe ends or chip select goes away
          if (cs_n_s || !strobe_act)
          begin
            host_data_bus_oe_n <= 16'hFFFF;
            transfer_ack_oe_n <= 1'b1;
            transfer_ack_out <= 1'b1;
            bus_r <= tdmsw_pkg::TDMSW_BUS_IDLE;
          end
        end
        default:
          bus_r <= tdmsw_pkg::TDMSW_BUS_IDLE;
      endcase
    end
  end
endmodule : tdmsw_top
`default_nettype wire

// [bench/tdmsw_top_monitor.sv]
// Port-level checker for the TDM switch stream and host port layer.
// Assumes bus style and mode pins only change between host accesses.
`timescale 1ns/100ps
`default_nettype none
module tdmsw_top_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Pins seen
  input wire logic low_clock_mode_pin_a,
  input wire logic low_clock_mode_pin_b,
  input wire logic bus_style_select,
  input wire logic stream_drive_enable,
  input wire logic chip_select_n,
  input wire logic strobe_or_read,
  // Outputs watched
  input wire logic [15:0] serial_out_streams_oe_n,
  input wire logic [15:0] host_data_bus_oe_n,
  input wire logic transfer_ack_out,
  input wire logic transfer_ack_oe_n,
  input wire logic clock_mode_4m,
  input wire logic clock_mode_reserved
);
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  chk_reset_quiet: assert property (disable iff (1'b0) rst |=>
    (&serial_out_streams_oe_n) && (&host_data_bus_oe_n) && transfer_ack_oe_n)
    else $error("outputs driven during reset");
  // Drive enable is synchronised, so allow its latency before judging
  chk_drive_gate: assert property (!stream_drive_enable [*6]
    |-> &serial_out_streams_oe_n) else $error("streams driven while disabled");
  chk_read_only_drive: assert property (host_data_bus_oe_n != 16'hFFFF
    |-> host_data_bus_oe_n == 16'h0000 && !transfer_ack_oe_n)
    else $error("data bus driven outside an access");
  chk_strobe_ack: assert property ($fell(transfer_ack_oe_n) && bus_style_select
    |-> transfer_ack_out ##2 (!transfer_ack_out || transfer_ack_oe_n))
    else $error("strobe style ack did not go low");
  chk_split_ack: assert property ($fell(transfer_ack_oe_n) && !bus_style_select
    |-> !transfer_ack_out ##2 (transfer_ack_out || transfer_ack_oe_n))
    else $error("separate style ack did not rise");
  chk_cs_ignore: assert property (chip_select_n [*8] |-> transfer_ack_oe_n)
    else $error("ack driven without chip select");
  chk_mode_decode: assert property (
    $stable({low_clock_mode_pin_a, low_clock_mode_pin_b}) [*8]
    |-> clock_mode_4m == (low_clock_mode_pin_a && low_clock_mode_pin_b)
    && clock_mode_reserved == (low_clock_mode_pin_a != low_clock_mode_pin_b))
    else $error("clock mode decode wrong");
  chk_ack_hold: assert property (!transfer_ack_oe_n && !transfer_ack_out
    && bus_style_select && !chip_select_n && !strobe_or_read |=> !transfer_ack_oe_n)
    else $error("ack released while strobe held");
  // ==========================================================================
  // Covers
  cov_strobe: cover property (!transfer_ack_oe_n && !transfer_ack_out && bus_style_select);
  cov_split: cover property (!transfer_ack_oe_n && transfer_ack_out && !bus_style_select);
  cov_mode4m: cover property (clock_mode_4m);
  cov_drive: cover property (!serial_out_streams_oe_n[0]);
endmodule : tdmsw_top_monitor

bind tdmsw_top tdmsw_top_monitor MON (.clock(clock), .rst(rst),
  .low_clock_mode_pin_a(low_clock_mode_pin_a), .low_clock_mode_pin_b(low_clock_mode_pin_b),
  .bus_style_select(bus_style_select), .stream_drive_enable(stream_drive_enable),
  .chip_select_n(chip_select_n), .strobe_or_read(strobe_or_read),
  .serial_out_streams_oe_n(serial_out_streams_oe_n), .host_data_bus_oe_n(host_data_bus_oe_n),
  .transfer_ack_out(transfer_ack_out), .transfer_ack_oe_n(transfer_ack_oe_n),
  .clock_mode_4m(clock_mode_4m), .clock_mode_reserved(clock_mode_reserved));
`default_nettype wire

// [bench/tdmsw_tdm_src.sv]
// Serial TDM source: frame clock, frame sync and input stream data.
// Assumes the bench clock is unrelated; frame shortened to FRAME_CK clocks.
`timescale 1ns/100ps
`default_nettype none
module tdmsw_tdm_src #(
  parameter int FRAME_CK = 256
) (
  // Frame timing
  output logic fck,
  output logic fsync_n,
  // Stream data
  output logic [15:0] sdata
);
  // ==========================================================================
  // Generator
  int cnt;
  initial
  begin
    cnt = 0;
    fck = 1'b1;
    fsync_n = 1'b1;
    sdata = 16'h0000;
    forever
    begin
      #62.5 fck = 1'b0;
      // Data toggles every bit so a stale sample never passes as fresh
      if (cnt[0])
        sdata = ~sdata;
      #62.5 fck = 1'b1;
      cnt = (cnt + 1) % FRAME_CK;
      fsync_n = (cnt != FRAME_CK - 1);
    end
  end
endmodule : tdmsw_tdm_src
`default_nettype wire

// [bench/tdmsw_top_test.sv]
// Self-checking bench for the TDM switch stream and host port layer.
// Assumes the design package is compiled first; the checker binds itself.
`timescale 1ns/100ps
`default_nettype none
module tdmsw_top_test;
  // ==========================================================================
  // Signals
  logic clock, rst, pin_a, pin_b, sty, de, cs_n, rw_n, sr, rdy;
  logic [13:0] adr;
  logic [15:0] din, dout, d_oe_n, so_out, so_oe_n, sin, got, rx;
  logic ack, ack_oe_n, m4, mres, cap, rxv, fck, fsync_n;
  wire logic [15:0] so_pin;
  wire logic ack_pin;
  int failures = 0;
  int n_compared = 0;
  // Pins have pull-downs, so a released stream reads low
  assign so_pin = so_out & ~so_oe_n;
  // Board pull-up in strobe style, pull-down in separate style
  assign ack_pin = ack_oe_n ? sty : ack;
  initial
  begin
    clock = 1'b0;
    forever
      #4 clock = ~clock;
  end
  initial
  begin
    {rst, cs_n, rw_n, sr, sty, de} = 6'b111110;
    {pin_a, pin_b, rdy} = 3'b000;
    adr = 14'h0000;
    din = 16'h0000;
  end
  tdmsw_tdm_src #(.FRAME_CK(256)) SRC (.fck(fck), .fsync_n(fsync_n), .sdata(sin));
  tdmsw_top DUT (.clock(clock), .rst(rst), .low_clock_mode_pin_a(pin_a),
    .low_clock_mode_pin_b(pin_b), .bus_style_select(sty), .frame_clock_input(fck),
    .frame_sync_input(fsync_n), .serial_in_streams(sin), .serial_out_streams_in(so_pin),
    .serial_out_streams_out(so_out), .serial_out_streams_oe_n(so_oe_n),
    .stream_drive_enable(de), .chip_select_n(cs_n), .read_write_n(rw_n),
    .strobe_or_read(sr), .host_address_bus(adr), .host_data_bus_in(din),
    .host_data_bus_out(dout), .host_data_bus_oe_n(d_oe_n), .transfer_ack_out(ack),
    .transfer_ack_oe_n(ack_oe_n), .clock_mode_4m(m4), .clock_mode_reserved(mres),
    .capacity_error(cap), .rx_word(rx), .rx_word_valid(rxv), .rx_word_ready(rdy));
  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic acc(input logic wr, input logic [13:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clock);
    adr <= a;
    din <= d;
    cs_n <= 1'b0;
    rw_n <= !wr;
    sr <= !sty && wr;
    do
    begin
      @(negedge clock);
      n++;
    end
    while (ack_pin !== !sty && n < 40);
    got = dout;
    if (n >= 40)
      failures++;
    @(posedge clock);
    {cs_n, rw_n, sr} <= 3'b111;
    repeat (8) @(posedge clock);
  endtask : acc
  task automatic conclude();
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude
  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    check(so_oe_n, 16'hFFFF);
    check({d_oe_n[0], ack_oe_n}, 2'b11);
    acc(0, tdmsw_pkg::ADDR_CR, 0);
    check(got, tdmsw_pkg::CR_RESET);
    acc(0, tdmsw_pkg::ADDR_IMS, 0);
    check(got, tdmsw_pkg::IMS_RESET);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_regs();
    logic [15:0] v [3] = '{16'h0380, 16'h0060, 16'h0000};
    for (int s = 1; s >= 0; s--)
    begin
      sty <= s[0];
      repeat (8) @(posedge clock);
      foreach (v[i])
      begin
        acc(1, tdmsw_pkg::ADDR_CR, v[i]);
        acc(0, tdmsw_pkg::ADDR_CR, 0);
        check(got, v[i]);
      end
    end
    $display("t_regs done");
  endtask : t_regs
  task automatic t_cs();
    @(posedge clock);
    sr <= 1'b0;
    rw_n <= 1'b0;
    repeat (20) @(posedge clock);
    check({d_oe_n[0], ack_oe_n}, 2'b11);
    {rw_n, sr} <= 2'b11;
    repeat (8) @(posedge clock);
    $display("t_cs done");
  endtask : t_cs
  task automatic t_mode();
    for (int p = 0; p < 4; p++)
    begin
      {pin_a, pin_b} <= p[1:0];
      repeat (10) @(posedge clock);
      check({mres, m4}, {p[0] ^ p[1], p[0] & p[1]});
      acc(0, tdmsw_pkg::ADDR_STATUS, 0);
      check(got & 16'h0003, {p[0] ^ p[1], p[0] & p[1]});
    end
    {pin_a, pin_b} <= 2'b00; // Pins tied together again
    $display("t_mode done");
  endtask : t_mode
  task automatic t_drive();
    acc(1, tdmsw_pkg::ADDR_SOCR, tdmsw_pkg::RATE_2M);
    de <= 1'b1;
    repeat (8) @(posedge clock);
    check(so_oe_n, 16'hFFFE);
    de <= 1'b0;
    repeat (8) @(posedge clock);
    check(so_oe_n, 16'hFFFF);
    $display("t_drive done");
  endtask : t_drive
  task automatic t_cap();
    for (int n = 0; n < 16; n++)
      acc(1, tdmsw_pkg::ADDR_SICR + 14'(n), tdmsw_pkg::RATE_4M);
    check(cap, 1'b0);
    acc(1, tdmsw_pkg::ADDR_SICR, tdmsw_pkg::RATE_8M);
    check(cap, 1'b1);
    for (int n = 1; n < 16; n++)
      acc(1, tdmsw_pkg::ADDR_SICR + 14'(n), tdmsw_pkg::RATE_OFF);
    acc(1, tdmsw_pkg::ADDR_SICR, tdmsw_pkg::RATE_2M);
    check(cap, 1'b0);
    $display("t_cap done");
  endtask : t_cap
  task automatic t_fifo();
    int k;
    k = 0;
    // No fill signal exists, so wait longer than 16 words of stream bits
    repeat (16000) @(posedge clock);
    // Drain in the gap around the frame boundary, where no word completes
    @(negedge fsync_n);
    @(posedge clock);
    rdy <= 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      @(negedge clock);
      if (rxv === 1'b1)
      begin
        k++;
        // Source toggles once per bit, so neighbouring bits always differ
        check((rx ^ (rx >> 1)) & 16'h7FFF, 16'h7FFF);
      end
    end
    @(posedge clock);
    rdy <= 1'b0;
    check(16'(k), 16'(tdmsw_pkg::FIFO_DEPTH));
    check(rxv, 1'b0);
    acc(1, tdmsw_pkg::ADDR_IMS, 16'h0040);
    repeat (30) @(posedge clock);
    check(so_out, 16'h0000);
    $display("t_fifo done");
  endtask : t_fifo
  // ==========================================================================
  // Main sequence and watchdog
  initial
  begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    // Scaled-down settling wait; only the pin latency matters here
    repeat (10) @(posedge clock);
    t_reset();
    t_regs();
    t_cs();
    t_mode();
    t_drive();
    t_cap();
    t_fifo();
    conclude();
  end
  initial
  begin
    repeat (60000) @(posedge clock);
    failures++;
    conclude();
  end
endmodule : tdmsw_top_test
`default_nettype wire
